//--- core/ebar_pkg.sv
// Package of constants and types for the external bus arbitration and ready block
package ebar_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int unsigned EBAR_ADDR_W   = 16;
  localparam int unsigned EBAR_DATA_W   = 16;
  localparam int unsigned EBAR_CS_W     = 4;
  localparam int unsigned EBAR_MCW_W    = 4;
  localparam int unsigned EBAR_RWD_W    = 1;

  // ----------------------------------------
  // Reset values and counts
  // ----------------------------------------
  localparam logic [EBAR_CS_W-1:0]  EBAR_CS_IDLE    = 4'hF;
  localparam logic [EBAR_MCW_W-1:0] EBAR_MCW_ZERO   = 4'h0;
  localparam logic [1:0]            EBAR_GAP_MUX    = 2'h1;
  localparam logic [1:0]            EBAR_GAP_TRI    = 2'h1;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [3:0] {
    EBAR_IDLE    = 4'b0000,
    EBAR_ADDR    = 4'b0001,
    EBAR_DELAY   = 4'b0010,
    EBAR_MCWAIT  = 4'b0011,
    EBAR_SAMPLE  = 4'b0100,
    EBAR_GAP     = 4'b0101,
    EBAR_RELEASE = 4'b0110,
    EBAR_HELD    = 4'b0111,
    EBAR_REGAIN  = 4'b1000
  } ebar_state_type;

endpackage

//--- core/ebar_hold_sampler.sv
// Sampler for the hold request and ready inputs
`timescale 1ns/1ns

module ebar_hold_sampler
  import ebar_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Raw pins, taken as synchronous
  input  wire logic hold_n_in,
  input  wire logic ready_n_in,
  // Sampled levels
  output logic      hold_req,
  output logic      ready_low
);

  typedef struct packed {
    logic hold_req;
    logic ready_low;
  } ebar_samp_type;

  ebar_samp_type s_r;
  ebar_samp_type s_nxt;

  always_comb begin
    s_nxt           = s_r;
    s_nxt.hold_req  = ~hold_n_in;
    s_nxt.ready_low = ~ready_n_in;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hold_req  = s_r.hold_req;
  assign ready_low = s_r.ready_low;

endmodule

//--- core/ebar_ctrl.sv
// External bus cycle sequencer with ready wait states and hold arbitration
`timescale 1ns/1ns

// What this block does
// - Cycle runs its programmed length with memory wait states before ready is sampled.
// - Strobe leading edge follows the programmed strobe delay setting.
// - Ready sampled high adds one wait state and samples again.
// - Ready sampled low ends the running bus cycle.
// - Multiplexed modes add one mux wait state after each cycle.
// - Enabled tristate wait adds one more wait state after the cycle.
// - Multiplexed bus with tristate wait gives a two clock gap.
// - Demultiplexed bus without tristate wait starts next cycle at once.
// - Hold request waits until the running cycle has finished.
// - Bus request never asserts before the bus is released and acknowledged.
// - Released bus leaves chip selects undriven, pulled high.
// - Regain starts only when hold returns high.
// - Regain sequence runs on hold removal, whether bus request was raised or not.
// - Next driven cycle may start as soon as regain ends.

module ebar_ctrl
  import ebar_pkg::*;
#(
  parameter int unsigned ADDR_W = EBAR_ADDR_W,
  parameter int unsigned DATA_W = EBAR_DATA_W,
  parameter int unsigned CS_W   = EBAR_CS_W
)
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // Configuration
  input  wire logic [3:0]        memory_cycle_wait_count,
  input  wire logic              rw_delay_enable,
  input  wire logic              mux_mode,
  input  wire logic              tristate_wait_enable,
  // Core access port
  input  wire logic              acc_req,
  input  wire logic              acc_write,
  input  wire logic [ADDR_W-1:0] acc_addr,
  input  wire logic [DATA_W-1:0] acc_wdata,
  input  wire logic [CS_W-1:0]   acc_cs_sel,
  output logic                   acc_done,
  output logic [DATA_W-1:0]      acc_rdata,
  // Ready and hold pins
  input  wire logic              ready_n,
  input  wire logic              hold_n,
  output logic                   hold_acknowledge_out,
  output logic                   bus_request_out,
  // Bus pins
  output logic [CS_W-1:0]        chip_select_out,
  output logic                   chip_select_oe,
  output logic [ADDR_W-1:0]      addr_out,
  output logic                   addr_oe,
  input  wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0]      data_out,
  output logic                   data_oe,
  output logic                   rd_n_out,
  output logic                   wr_n_out,
  output logic                   ctrl_oe
);

  // ----------------------------------------
  // Sampled inputs
  // ----------------------------------------
  logic hold_req;
  logic ready_low;

  ebar_hold_sampler u_samp (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .hold_n_in  (hold_n),
    .ready_n_in (ready_n),
    .hold_req   (hold_req),
    .ready_low  (ready_low)
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    ebar_state_type     st;
    logic [3:0]         wcnt;
    logic [1:0]         gap;
    logic               wr;
    logic [ADDR_W-1:0]  addr;
    logic [DATA_W-1:0]  wdata;
    logic [CS_W-1:0]    cs;
    logic               done;
    logic [DATA_W-1:0]  rdata;
    logic               hold_acknowledge_out_n;
    logic               bus_request_out_n;
    logic               cs_oe;
    logic               bus_oe;
    logic               data_oe;
    logic               rd_n;
    logic               wr_n;
  } ebar_ctl_type;

  ebar_ctl_type c_r;
  ebar_ctl_type c_nxt;

  always_comb begin
    c_nxt      = c_r;
    c_nxt.done = 1'b0;
    case (c_r.st)
      EBAR_IDLE: begin
        if (hold_req) begin
          // Only idle bus is granted, so a running cycle always finishes
          c_nxt.st     = EBAR_RELEASE;
          c_nxt.cs_oe  = 1'b0;
          c_nxt.bus_oe = 1'b0;
          c_nxt.data_oe = 1'b0;
        end else if (acc_req) begin
          c_nxt.st    = EBAR_ADDR;
          c_nxt.wr    = acc_write;
          c_nxt.addr  = acc_addr;
          c_nxt.wdata = acc_wdata;
          c_nxt.cs    = ~acc_cs_sel;
        end
      end
      EBAR_ADDR: begin
        c_nxt.wcnt = memory_cycle_wait_count;
        if (rw_delay_enable) begin
          // Strobe leading edge held back one clock
          c_nxt.st = EBAR_DELAY;
        end else begin
          c_nxt.st      = EBAR_MCWAIT;
          c_nxt.rd_n    = c_r.wr;
          c_nxt.wr_n    = ~c_r.wr;
          c_nxt.data_oe = c_r.wr;
        end
      end
      EBAR_DELAY: begin
        c_nxt.st      = EBAR_MCWAIT;
        c_nxt.rd_n    = c_r.wr;
        c_nxt.wr_n    = ~c_r.wr;
        c_nxt.data_oe = c_r.wr;
      end
      EBAR_MCWAIT: begin
        // Programmed length first, ready looked at only afterwards
        if (c_r.wcnt == EBAR_MCW_ZERO) begin
          c_nxt.st = EBAR_SAMPLE;
        end else begin
          c_nxt.wcnt = c_r.wcnt - 4'h1;
        end
      end
      EBAR_SAMPLE: begin
        if (ready_low) begin
          // Cycle ends, strobe rises so the peripheral may drop ready
          c_nxt.rd_n    = 1'b1;
          c_nxt.wr_n    = 1'b1;
          c_nxt.done    = 1'b1;
          c_nxt.data_oe = 1'b0;
          if (!c_r.wr) begin
            c_nxt.rdata = data_in;
          end
          c_nxt.cs  = EBAR_CS_IDLE;
          c_nxt.gap = (mux_mode ? EBAR_GAP_MUX : 2'h0)
                    + (tristate_wait_enable ? EBAR_GAP_TRI : 2'h0);
          // No gap, no delay before next cycle
          c_nxt.st  = (mux_mode || tristate_wait_enable) ? EBAR_GAP : EBAR_IDLE;
        end
        // Ready high: stay one more wait state and sample again
      end
      EBAR_GAP: begin
        if (c_r.gap == 2'h1) begin
          c_nxt.st = EBAR_IDLE;
        end
        c_nxt.gap = c_r.gap - 2'h1;
      end
      EBAR_RELEASE: begin
        // Acknowledge only once all drivers are off
        c_nxt.hold_acknowledge_out_n = 1'b0;
        c_nxt.st     = EBAR_HELD;
      end
      EBAR_HELD: begin
        // Bus request only after release and acknowledge
        c_nxt.bus_request_out_n = ~acc_req;
        if (!hold_req) begin
          // Regain runs on hold release, requested or not
          c_nxt.hold_acknowledge_out_n = 1'b1;
          c_nxt.bus_request_out_n = 1'b1;
          c_nxt.st     = EBAR_REGAIN;
        end
      end
      EBAR_REGAIN: begin
        // Drivers back on one clock after acknowledge drops
        c_nxt.cs_oe  = 1'b1;
        c_nxt.bus_oe = 1'b1;
        c_nxt.st     = EBAR_IDLE;
      end
      default: begin
        c_nxt.st = EBAR_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      c_r        <= '0;
      c_r.st     <= EBAR_IDLE;
      c_r.cs     <= EBAR_CS_IDLE;
      c_r.hold_acknowledge_out_n <= 1'b1;
      c_r.bus_request_out_n <= 1'b1;
      c_r.cs_oe  <= 1'b1;
      c_r.bus_oe <= 1'b1;
      c_r.rd_n   <= 1'b1;
      c_r.wr_n   <= 1'b1;
    end else begin
      c_r <= c_nxt;
    end
  end

  // ----------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------
  assign acc_done             = c_r.done;
  assign acc_rdata            = c_r.rdata;
  assign hold_acknowledge_out = c_r.hold_acknowledge_out_n;
  assign bus_request_out      = c_r.bus_request_out_n;
  assign chip_select_out      = c_r.cs;
  assign chip_select_oe       = c_r.cs_oe;
  assign addr_out             = c_r.addr;
  assign addr_oe              = c_r.bus_oe;
  assign data_out             = c_r.wdata;
  assign data_oe              = c_r.data_oe;
  assign rd_n_out             = c_r.rd_n;
  assign wr_n_out             = c_r.wr_n;
  assign ctrl_oe              = c_r.bus_oe;

endmodule

//--- dv/ebar_ctrl_checker.sv
// Port-level assertions for the bus sequencer
`timescale 1ns/1ns

module ebar_ctrl_checker
  import ebar_pkg::*;
#(
  parameter int unsigned CS_W = EBAR_CS_W
)
(
  // Clock, reset, setup
  input wire logic            ref_clk,
  input wire logic            rst_n,
  input wire logic            rw_delay_enable,
  input wire logic            mux_mode,
  input wire logic            tristate_wait_enable,
  // Core side and pins
  input wire logic            acc_req,
  input wire logic            acc_done,
  input wire logic            ready_n,
  input wire logic            hold_n,
  input wire logic            hold_acknowledge_out,
  input wire logic            bus_request_out,
  input wire logic [CS_W-1:0] chip_select_out,
  input wire logic            chip_select_oe,
  input wire logic            rd_n_out,
  input wire logic            wr_n_out,
  input wire logic            ctrl_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire stb = !(rd_n_out && wr_n_out);
  wire cs_hi = &chip_select_out;
  sequence s_start; $fell(cs_hi); endsequence
  sequence s_end; $rose(cs_hi); endsequence
  property p_dly; s_start |=> stb != $past(rw_delay_enable); endproperty
  a_dly: assert property (p_dly) else $error("strobe start");
  property p_rhi; (ready_n && stb)[*3] |=> stb; endproperty
  a_rhi: assert property (p_rhi) else $error("ended on ready high");
  property p_rlo; s_end |-> $past(!ready_n) || $past(!ready_n, 2) || $past(!ready_n, 3);
  endproperty
  a_rlo: assert property (p_rlo) else $error("ended without ready");
  property p_gap2; s_end and mux_mode && tristate_wait_enable |-> cs_hi[*3]; endproperty
  a_gap2: assert property (p_gap2) else $error("gap short");
  property p_gap0; acc_done && hold_n && !mux_mode && !tristate_wait_enable ##1 acc_req
    |-> ##[0:2] !cs_hi; endproperty
  a_gap0: assert property (p_gap0) else $error("gap added");
  property p_busy; stb |-> hold_acknowledge_out; endproperty
  a_busy: assert property (p_busy) else $error("granted in cycle");
  property p_bus_request_out; !bus_request_out |-> !hold_acknowledge_out && !chip_select_oe; endproperty
  a_bus_request_out: assert property (p_bus_request_out) else $error("early request");
  property p_float; !hold_acknowledge_out |-> !chip_select_oe && !ctrl_oe; endproperty
  a_float: assert property (p_float) else $error("bus driven");
  property p_regain; $rose(hold_n) && !hold_acknowledge_out
    |-> ##[1:3] (hold_acknowledge_out && bus_request_out) ##[1:2] chip_select_oe; endproperty
  a_regain: assert property (p_regain) else $error("regain");
endmodule

bind ebar_ctrl ebar_ctrl_checker #(.CS_W(CS_W)) u_chk (.*);

//--- dv/ebar_far_model.sv
// Far-side peripheral: ready responder and read data source
`timescale 1ns/1ns

module ebar_far_model (
  // Clock and strobes
  input wire logic       ref_clk,
  input wire logic       rd_n_out,
  input wire logic       wr_n_out,
  // Ready latency in clocks
  input wire logic [3:0] ready_delay,
  // Answer
  output logic           ready_n,
  output logic [15:0]    data_in
);
  logic [3:0] cnt_r   = 4'h0;
  logic       rdy_n_r = 1'b1;

  always @(posedge ref_clk) begin
    if (rd_n_out && wr_n_out) begin
      cnt_r   <= 4'h0;
      rdy_n_r <= 1'b1; // Let go on strobe trailing edge
    end else if (cnt_r == ready_delay) begin
      rdy_n_r <= 1'b0; // Low until strobe ends, so async timing holds
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
  assign ready_n = rdy_n_r;
  // Inverse pattern when not read, so stale data never passes
  assign data_in = rd_n_out ? 16'h3C3C : 16'hC3C3;
endmodule

//--- dv/tb.sv
// Self-checking bench for the bus sequencer
`timescale 1ns/1ns

module tb;
  logic        ref_clk, rst_n, rw_delay_enable, mux_mode, tristate_wait_enable;
  logic        acc_req, acc_write, acc_done, ready_n, hold_n, ctrl_oe;
  logic        hold_acknowledge_out, bus_request_out, chip_select_oe, addr_oe;
  logic        data_oe, rd_n_out, wr_n_out;
  logic [3:0]  memory_cycle_wait_count, acc_cs_sel, chip_select_out, ready_delay;
  logic [15:0] acc_addr, acc_wdata, acc_rdata, addr_out, data_in, data_out;
  int          error_cnt = 0;
  int          checked = 0;

  ebar_ctrl uut (.*);
  ebar_far_model far (.*);

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // ----
  // Helpers
  // ----
  task automatic final_report;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wt(ref logic s, input logic v);
    int n = 0;
    // Always step one edge first, so a pulse from the last call is never seen
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (s !== v && n < 300);
    chk({15'h0000, s}, {15'h0000, v});
    if (s !== v) final_report();
  endtask
  task automatic acc(input logic wr, input logic [3:0] w, input logic [3:0] rd,
                     input logic d, input logic keep, input int lead);
    time t0;
    int  e;
    @(posedge ref_clk);
    t0 = $time;
    // Peripheral counts from strobe, so memory waits and ready delay overlap
    e = lead + 1 + d + ((w + 2 > rd + 3) ? w + 2 : rd + 3);
    acc_write <= wr;
    memory_cycle_wait_count <= w;
    ready_delay <= rd;
    rw_delay_enable <= d;
    acc_req <= 1'b1;
    wt(acc_done, 1'b1);
    chk(16'(($time - t0) / 100), 16'(e));
    chk({12'h000, chip_select_out}, 16'h000F);
    if (!wr) chk(acc_rdata, 16'hC3C3);
    else chk(data_out, 16'h5A5A);
    // Dropped in the done cycle unless keep is set, else the idle sequencer restarts
    acc_req <= keep;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic s_cycles;
    for (int i = 0; i < 8; i++) acc(i[0], {2'h0, i[2:1]}, {2'h0, i[1:0]}, i[2], 1'b0, 1);
  endtask
  task automatic s_gaps;
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      mux_mode <= i[0];
      tristate_wait_enable <= i[1];
      acc(1'b1, 4'h0, 4'h0, 1'b0, 1'b1, 1);
      acc(1'b1, 4'h0, 4'h0, 1'b0, 1'b0, int'(i[0]) + int'(i[1]));
    end
  endtask
  task automatic s_hold;
    @(posedge ref_clk);
    acc_write <= 1'b0;
    ready_delay <= 4'h3;
    acc_req <= 1'b1;
    wt(rd_n_out, 1'b0);
    chk({12'h000, chip_select_out}, 16'h000D);
    chk(addr_out, 16'h0100);
    chk({15'h0000, data_oe}, 16'h0000);
    hold_n <= 1'b0;
    wt(acc_done, 1'b1);
    wt(hold_acknowledge_out, 1'b1);
    wt(hold_acknowledge_out, 1'b0);
    wt(chip_select_oe, 1'b0);
    chk({14'h0000, addr_oe, ctrl_oe}, 16'h0000);
    wt(bus_request_out, 1'b0);
    hold_n <= 1'b1;
    wt(hold_acknowledge_out, 1'b1);
    wt(bus_request_out, 1'b1);
    wt(acc_done, 1'b1);
    chk(acc_rdata, 16'hC3C3);
    acc_req <= 1'b0;
  endtask
  task automatic s_free;
    @(posedge ref_clk);
    hold_n <= 1'b0;
    wt(hold_acknowledge_out, 1'b0);
    repeat (4) @(posedge ref_clk);
    hold_n <= 1'b1;
    wt(bus_request_out, 1'b1);
    wt(hold_acknowledge_out, 1'b1);
    acc(1'b0, 4'h0, 4'h0, 1'b0, 1'b0, 1);
  endtask

  initial begin
    rst_n = 1'b0;
    {rw_delay_enable, mux_mode, tristate_wait_enable, acc_req, acc_write} = 5'h00;
    hold_n = 1'b1;
    memory_cycle_wait_count = 4'h0;
    acc_cs_sel = 4'h2;
    ready_delay = 4'h0;
    acc_addr = 16'h0100;
    acc_wdata = 16'h5A5A;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    s_cycles();
    s_gaps();
    s_hold();
    s_free();
    final_report();
  end
endmodule
